// File: core/dslf_pkg.sv
// dslf_pkg: constants, types and helpers of the pair line framer
// Operation
// - core frame: 144 bytes every 500 us
// - core frames form one unbroken 2304 kbit/s stream
// - core bytes dealt to pairs in rotation
// - layout is binary, before scrambling and coding
// - framing runs only once link is up
// - line frame nominally lasts 6 ms
// - three pairs: mean 2352 symbols, 4704 bits
// - three pairs: 2351 or 2353 symbols per frame
// - two pairs: mean 3504, 3503 or 3505
// - one pair: mean 6960, 6959 or 6961
// - timing slack absorbed by zero or two stuff symbols
// - all pair frames timed from one source
// - frame starts on all pairs aligned
// - same stuff decision on every pair
// - bits 1-14 sync, 15 input loss, 16 block error
// - four payload groups of twelve blocks, overhead between
// - power status bits sent by remote unit only
// - stuff symbols sent only when stuffing applies
// - sign then magnitude bit per symbol
// - symbol rate 392, 584 or 1160 kbaud
package dslf_pkg;
   localparam int NP = 3;
   localparam int CLK_HZ = 10_000_000;
   localparam int CORE_BYTES = 144;
   localparam int CORE_US = 500;
   localparam int CORE_KBPS = 2304;
   localparam int FRAME_US = 6000;
   localparam int BAUD_3 = 392_000;
   localparam int BAUD_2 = 584_000;
   localparam int BAUD_1 = 1_160_000;
   // header, three overhead sections and one stuff symbol of the mean frame
   localparam int FIXED_BITS = 48;
   localparam int GROUPS = 4;
   localparam int SYNC_END = 14;
   localparam int HDR_END = 16;
   localparam int OVH_BITS = 10;
   localparam int PS_A_SLOT = 6;
   localparam logic [3:0] STUFF_PAT = 4'h0;
   localparam logic [5:0] CRC_POLY = 6'h03;
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_OVH = 12'h004;
   localparam logic [11:0] REG_STAT = 12'h008;
   localparam int CTRL_EN = 0;
   localparam int CTRL_MODE = 1;
   localparam int CTRL_REMOTE = 3;
   localparam int OVH_EOC = 0;
   localparam int OVH_LOSS = 13;
   localparam int OVH_BERR = 14;
   localparam int OVH_BPV = 15;
   localparam int OVH_RTA = 16;
   localparam int OVH_READY = 17;
   localparam int OVH_SPARE = 18;
   localparam int OVH_PS = 20;
   localparam int OVH_REGEN = 22;
   localparam int STAT_FILL = 0;
   localparam int STAT_STUFF = 8;
   localparam int STAT_UNDER = 9;
   localparam int STAT_FRAMES = 16;
   localparam logic [31:0] CTRL_RST = 32'h0000_0006;
   localparam logic [25:0] OVH_RST = 26'h000_0000;

   typedef enum logic [1:0] {
      DSLF_ILLEGAL = 2'h0,
      DSLF_ONE = 2'h1,
      DSLF_TWO = 2'h2,
      DSLF_THREE = 2'h3
   } dslf_pairs_t;

   // an unused mode code falls back to three pairs
   function automatic int baud_of(input logic [1:0] m);
      unique case (m)
         DSLF_ONE: baud_of = BAUD_1;
         DSLF_TWO: baud_of = BAUD_2;
         default: baud_of = BAUD_3;
      endcase
   endfunction

   // mean symbols per frame: one nominal frame time at the symbol rate
   function automatic int mean_of(input logic [1:0] m);
      mean_of = baud_of(m) / 1000 * FRAME_US / 1000;
   endfunction
endpackage

// File: core/dslf_framer.sv
// dslf_framer: core-frame intake, elastic buffer and per-pair line framer
`timescale 1ns/100ps
module dslf_framer #(
   parameter int FIFO_DEPTH = 16,
   parameter logic [13:0] SYNC_WORD = 14'h0000
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] app_data,
   input wire logic app_valid,
   output logic app_ready,
   output logic core_sof,
   output logic [dslf_pkg::NP-1:0] line_sign,
   output logic [dslf_pkg::NP-1:0] line_mag,
   output logic line_valid,
   output logic line_sof
);
   localparam int NP = dslf_pkg::NP;
   localparam int AW = $clog2(FIFO_DEPTH);

   logic en;
   logic remote;
   logic [1:0] mode;
   logic [25:0] ovh;
   logic [15:0] frames;
   logic underrun;

   function automatic logic [5:0] crc2(input logic [5:0] c, input logic [1:0] b);
      logic [5:0] r;
      r = c;
      for (int i = 1; i >= 0; i--) begin
         r = {r[4:0], 1'b0} ^ ((r[5] ^ b[i]) ? dslf_pkg::CRC_POLY : 6'h00);
      end
      return r;
   endfunction

   // frame geometry follows the pair count
   logic [20:0] baud;
   logic [13:0] mean;
   logic [13:0] grp;
   logic [13:0] o1;
   logic [13:0] o2;
   logic [13:0] o3;
   logic [13:0] st;
   logic [1:0] npairs;
   always_comb begin
      baud = 21'(dslf_pkg::baud_of(mode));
      mean = 14'(dslf_pkg::mean_of(mode));
      grp = 14'((2 * dslf_pkg::mean_of(mode) - dslf_pkg::FIXED_BITS) / dslf_pkg::GROUPS);
      o1 = 14'(dslf_pkg::HDR_END + 1) + grp;
      o2 = o1 + 14'(dslf_pkg::OVH_BITS) + grp;
      o3 = o2 + 14'(dslf_pkg::OVH_BITS) + grp;
      st = o3 + 14'(dslf_pkg::OVH_BITS) + grp;
      unique case (mode)
         dslf_pkg::DSLF_ONE: npairs = 2'h1;
         dslf_pkg::DSLF_TWO: npairs = 2'h2;
         default: npairs = 2'h3;
      endcase
   end

   // one fractional symbol tick shared by all pairs
   logic [23:0] acc;
   logic sym_tick;
   logic [24:0] acc_sum;
   assign acc_sum = {1'b0, acc} + {4'h0, baud};
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc <= 24'h000000;
         sym_tick <= 1'b0;
      end else if (!en) begin
         acc <= 24'h000000;
         sym_tick <= 1'b0;
      end else if (acc_sum >= 25'(dslf_pkg::CLK_HZ)) begin
         acc <= 24'(acc_sum - 25'(dslf_pkg::CLK_HZ));
         sym_tick <= 1'b1;
      end else begin
         acc <= acc_sum[23:0];
         sym_tick <= 1'b0;
      end
   end

   // elastic buffer between application and line timing
   logic [7:0] mem [FIFO_DEPTH];
   logic [AW-1:0] wp;
   logic [AW-1:0] rp;
   logic [AW:0] cnt;
   logic [AW:0] next_cnt;
   logic push;
   logic pop;
   assign push = app_valid & app_ready;
   assign next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wp] <= app_data;
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wp <= '0;
         rp <= '0;
         cnt <= '0;
         app_ready <= 1'b0;
      end else begin
         wp <= wp + AW'(push);
         rp <= rp + AW'(pop);
         cnt <= next_cnt;
         app_ready <= (next_cnt < (AW+1)'(FIFO_DEPTH));
      end
   end

   // core frame boundary: every 144th accepted byte opens a frame
   logic [7:0] core_idx;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         core_idx <= 8'h00;
         core_sof <= 1'b0;
      end else begin
         core_sof <= push && (core_idx == 8'h00);
         if (push) begin
            core_idx <= (core_idx == 8'(dslf_pkg::CORE_BYTES - 1)) ? 8'h00 : core_idx + 8'h01;
         end
      end
   end

   // byte dealer: one byte per pair in turn, ahead of need
   logic [7:0] hold [NP];
   logic [NP-1:0] hold_ok;
   logic [1:0] rot;
   logic reload;
   assign pop = en && (cnt != '0) && !hold_ok[rot] && !reload;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_ok <= '0;
         rot <= 2'h0;
         for (int p = 0; p < NP; p++) begin
            hold[p] <= 8'h00;
         end
      end else if (!en) begin
         hold_ok <= '0;
         rot <= 2'h0;
      end else begin
         if (reload) begin
            hold_ok <= '0;
         end
         if (pop) begin
            hold[rot] <= mem[rp];
            hold_ok[rot] <= 1'b1;
            rot <= (rot == npairs - 2'h1) ? 2'h0 : rot + 2'h1;
         end
      end
   end

   // symbol composer
   logic [13:0] pos;
   logic stuff;
   logic [3:0] bits_left;
   logic [7:0] shreg [NP];
   logic [5:0] crc [NP];
   logic [5:0] crc_prev [NP];
   logic is_sync;
   logic is_hdr;
   logic is_stuff;
   logic is_ovh;
   logic is_pay;
   logic last;
   logic [13:0] ovh_idx;
   logic [7:0] data [NP];
   logic [1:0] sym [NP];
   logic [5:0] next_crc [NP];
   logic [29:0] ovh_word [NP];
   logic [13:0] sync_sh;
   logic [3:0] stuff_sh;
   logic [1:0] ps;
   assign ps = remote ? ovh[dslf_pkg::OVH_PS +: 2] : 2'h0;
   always_comb begin
      is_sync = pos <= 14'(dslf_pkg::SYNC_END);
      is_hdr = !is_sync && pos <= 14'(dslf_pkg::HDR_END);
      is_stuff = pos >= st;
      is_ovh = 1'b1;
      if (pos >= o1 && pos < o1 + 14'(dslf_pkg::OVH_BITS)) begin
         ovh_idx = pos - o1;
      end else if (pos >= o2 && pos < o2 + 14'(dslf_pkg::OVH_BITS)) begin
         ovh_idx = pos - o2 + 14'(dslf_pkg::OVH_BITS);
      end else if (pos >= o3 && pos < o3 + 14'(dslf_pkg::OVH_BITS)) begin
         ovh_idx = pos - o3 + 14'(2 * dslf_pkg::OVH_BITS);
      end else begin
         ovh_idx = 14'h0000;
         is_ovh = 1'b0;
      end
      is_pay = !is_sync && !is_hdr && !is_stuff && !is_ovh;
      last = stuff ? (pos == st + 14'h0002) : (pos == st - 14'h0002);
      reload = sym_tick && is_pay && (bits_left == 4'h0);
      sync_sh = SYNC_WORD << (pos - 14'h0001);
      stuff_sh = dslf_pkg::STUFF_PAT << 2'(pos - st);
      for (int p = 0; p < NP; p++) begin
         data[p] = (bits_left == 4'h0) ? hold[p] : shreg[p];
         ovh_word[p] = {
            ovh[dslf_pkg::OVH_EOC +: 4], crc_prev[p][5:4], ps,
            ovh[dslf_pkg::OVH_BPV], ovh[dslf_pkg::OVH_EOC + 4],
            ovh[dslf_pkg::OVH_EOC + 5 +: 4], crc_prev[p][3:2],
            ovh[dslf_pkg::OVH_REGEN +: 4],
            ovh[dslf_pkg::OVH_EOC + 9 +: 4], crc_prev[p][1:0],
            ovh[dslf_pkg::OVH_RTA], ovh[dslf_pkg::OVH_READY],
            ovh[dslf_pkg::OVH_SPARE +: 2]};
         if (is_sync) begin
            sym[p] = sync_sh[13:12];
         end else if (is_hdr) begin
            sym[p] = {ovh[dslf_pkg::OVH_LOSS], ovh[dslf_pkg::OVH_BERR]};
         end else if (is_stuff) begin
            sym[p] = stuff_sh[3:2];
         end else if (is_ovh) begin
            sym[p] = 2'(ovh_word[p] >> (14'd28 - ovh_idx));
         end else begin
            sym[p] = data[p][7:6];
         end
         next_crc[p] = (is_sync || is_stuff) ? crc[p] : crc2(crc[p], sym[p]);
      end
   end

   logic [13:0] out_pos;
   logic [13:0] sym_cnt;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pos <= 14'h0001;
         stuff <= 1'b0;
         bits_left <= 4'h0;
         line_valid <= 1'b0;
         line_sof <= 1'b0;
         line_sign <= '0;
         line_mag <= '0;
         out_pos <= 14'h0000;
         sym_cnt <= 14'h0000;
         frames <= 16'h0000;
         for (int p = 0; p < NP; p++) begin
            shreg[p] <= 8'h00;
            crc[p] <= 6'h00;
            crc_prev[p] <= 6'h00;
         end
      end else if (!en) begin
         pos <= 14'h0001;
         bits_left <= 4'h0;
         line_valid <= 1'b0;
         line_sof <= 1'b0;
         sym_cnt <= 14'h0000;
         for (int p = 0; p < NP; p++) begin
            crc[p] <= 6'h00;
         end
      end else begin
         line_valid <= sym_tick;
         line_sof <= sym_tick && (pos == 14'h0001);
         if (sym_tick) begin
            out_pos <= pos;
            for (int p = 0; p < NP; p++) begin
               line_sign[p] <= sym[p][1];
               line_mag[p] <= sym[p][0];
               if (is_pay) begin
                  shreg[p] <= data[p] << 2;
               end
            end
            if (pos == 14'h0001) begin
               // a thin buffer means the far side is slower: stretch the frame
               stuff <= (cnt < (AW+1)'(FIFO_DEPTH / 2));
            end
            if (is_pay) begin
               bits_left <= ((bits_left == 4'h0) ? 4'h8 : bits_left) - 4'h2;
            end
            if (last) begin
               pos <= 14'h0001;
               sym_cnt <= 14'h0000;
               frames <= frames + 16'h0001;
               for (int p = 0; p < NP; p++) begin
                  crc_prev[p] <= next_crc[p];
                  crc[p] <= 6'h00;
               end
            end else begin
               pos <= pos + 14'h0002;
               sym_cnt <= sym_cnt + 14'h0001;
               for (int p = 0; p < NP; p++) begin
                  crc[p] <= next_crc[p];
               end
            end
         end
      end
   end

   // sticky until disabled: pair 0 ran out of bytes at a byte boundary
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         underrun <= 1'b0;
      end else if (!en) begin
         underrun <= 1'b0;
      end else if (reload && !hold_ok[0]) begin
         underrun <= 1'b1;
      end
   end

   // apb slave, zero wait states
   logic [31:0] status;
   logic setup;
   assign setup = psel && !penable && !pready;
   always_comb begin
      status = 32'h0000_0000;
      status[dslf_pkg::STAT_FILL +: AW+1] = cnt;
      status[dslf_pkg::STAT_STUFF] = stuff;
      status[dslf_pkg::STAT_UNDER] = underrun;
      status[dslf_pkg::STAT_FRAMES +: 16] = frames;
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         en <= dslf_pkg::CTRL_RST[dslf_pkg::CTRL_EN];
         mode <= dslf_pkg::CTRL_RST[dslf_pkg::CTRL_MODE +: 2];
         remote <= dslf_pkg::CTRL_RST[dslf_pkg::CTRL_REMOTE];
         ovh <= dslf_pkg::OVH_RST;
      end else begin
         pready <= setup;
         if (setup) begin
            pslverr <= 1'b0;
            unique case (paddr)
               dslf_pkg::REG_CTRL: prdata <= {28'h0000000, remote, mode, en};
               dslf_pkg::REG_OVH: prdata <= {6'h00, ovh};
               dslf_pkg::REG_STAT: prdata <= status;
               default: begin
                  prdata <= 32'h0000_0000;
                  pslverr <= 1'b1;
               end
            endcase
         end
         if (psel && penable && pready && pwrite) begin
            if (paddr == dslf_pkg::REG_CTRL) begin
               en <= pwdata[dslf_pkg::CTRL_EN];
               mode <= pwdata[dslf_pkg::CTRL_MODE +: 2];
               remote <= pwdata[dslf_pkg::CTRL_REMOTE];
            end
            if (paddr == dslf_pkg::REG_OVH) begin
               ovh <= pwdata[25:0];
            end
         end
      end
   end

   AST_TICK_GAP: assert property (@(posedge core_clk) disable iff (!rst_n)
      sym_tick |=> !sym_tick [*7])
      else $error("symbol ticks closer than the fastest rate allows");
   AST_FRAME_LEN: assert property (@(posedge core_clk) disable iff (!rst_n)
      sym_tick && last |-> (stuff ? sym_cnt == mean : sym_cnt == mean - 14'h0002))
      else $error("line frame length is not mean minus or plus one");
   AST_SOF_SYNC: assert property (@(posedge core_clk) disable iff (!rst_n)
      line_sof |-> line_valid && {line_sign[0], line_mag[0]} == SYNC_WORD[13:12])
      else $error("frame start does not carry the sync pattern");
   AST_STUFF_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
      en && !(sym_tick && pos == 14'h0001) |=> $stable(stuff))
      else $error("stuff decision changed inside a frame");
   AST_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n)
      !en |=> !line_valid && !line_sof)
      else $error("line symbols sent while link is down");
   AST_FIFO_BOUND: assert property (@(posedge core_clk) disable iff (!rst_n)
      cnt == (AW+1)'(FIFO_DEPTH) |-> !app_ready)
      else $error("elastic buffer full but still accepting");
   AST_CORE_SOF: assert property (@(posedge core_clk) disable iff (!rst_n)
      core_sof |-> core_idx == 8'h01)
      else $error("core frame start not on byte zero");
   AST_PS_LOCAL: assert property (@(posedge core_clk) disable iff (!rst_n)
      line_valid && !remote && out_pos == o1 + 14'(dslf_pkg::PS_A_SLOT)
      |-> line_sign == '0 && line_mag == '0)
      else $error("power status sent by the central unit");
   AST_CRC_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
      !(sym_tick && last) |=> $stable(crc_prev[0]))
      else $error("frame check changed outside a frame end");
   AST_ROTATE: assert property (@(posedge core_clk) disable iff (!rst_n)
      pop && npairs != 2'h1 |=> rot != $past(rot))
      else $error("byte dealer did not move to the next pair");
endmodule // dslf_framer

// File: verif/dslf_remote_rx.sv
// dslf_remote_rx: remote-end receiver model capturing one line frame per pair
`timescale 1ns/100ps
module dslf_remote_rx (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [dslf_pkg::NP-1:0] line_sign,
   input wire logic [dslf_pkg::NP-1:0] line_mag,
   input wire logic line_valid,
   input wire logic line_sof,
   output int frame_len,
   output int frames
);
   // bits numbered from 1 as on the line; sized for a stuffed three-pair frame
   logic [1:4706] fb [dslf_pkg::NP];
   logic [1:4706] cur [dslf_pkg::NP];
   int sym;
   int idx;
   always_comb idx = line_sof ? 0 : sym;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sym <= 0;
         frames <= 0;
         frame_len <= 0;
      end else if (line_valid) begin
         if (line_sof) begin
            frames <= frames + 1;
            frame_len <= sym;
            fb <= cur;
            sym <= 1;
         end else begin
            sym <= sym + 1;
         end
         // longer frames than the buffer are simply not recorded past its end
         for (int p = 0; p < dslf_pkg::NP; p++) begin
            if (idx < 2353) begin
               cur[p][2*idx+1] <= line_sign[p];
               cur[p][2*idx+2] <= line_mag[p];
            end
         end
      end
   end
endmodule // dslf_remote_rx

// File: verif/dsl_core_and_line_framer_tb.sv
// dsl_core_and_line_framer_tb: directed bench for the pair line framer
`timescale 1ns/100ps
module dsl_core_and_line_framer_tb;
   // arbitrary sync pattern chosen for this bench
   localparam logic [13:0] SYNC = 14'h1A5C;
   logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [7:0] app_data;
   logic app_valid, app_ready, core_sof, line_valid, line_sof;
   logic [dslf_pkg::NP-1:0] line_sign, line_mag;
   int frame_len, frames, errors, n_tests, cyc, nsym, nsof;
   int taken = 0;
   int feed_lim = 0;

   dslf_framer #(.FIFO_DEPTH(16), .SYNC_WORD(SYNC)) dut (.core_clk(core_clk), .rst_n(rst_n),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .app_data(app_data),
      .app_valid(app_valid), .app_ready(app_ready), .core_sof(core_sof),
      .line_sign(line_sign), .line_mag(line_mag), .line_valid(line_valid), .line_sof(line_sof));
   dslf_remote_rx rx (.core_clk(core_clk), .rst_n(rst_n), .line_sign(line_sign),
      .line_mag(line_mag), .line_valid(line_valid), .line_sof(line_sof),
      .frame_len(frame_len), .frames(frames));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // byte value equals its stream position, so placement on the line is traceable
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (line_valid === 1'b1) nsym <= nsym + 1;
      if (app_valid && app_ready) begin
         taken <= taken + 1;
         app_data <= app_data + 8'h01;
      end
      app_valid <= (taken + 2 < feed_lim);
      if (core_sof === 1'b1) begin
         nsof <= nsof + 1;
         chk("core_sof_pos", 32'(taken % 144), 32'h1);
      end
   end

   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
         output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         errors++;
         close_out();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_sof(input int lim);
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (!(line_valid === 1'b1 && line_sof === 1'b1) && n < lim);
      if (n >= lim) begin
         errors++;
         close_out();
      end
   endtask

   // check of a stuffed three-pair frame: bit 15 up to the last payload bit
   function automatic logic [5:0] crc_ref(input int p);
      logic [5:0] c;
      c = 6'h00;
      for (int b = 15; b <= 4702; b++) begin
         c = {c[4:0], 1'b0} ^ ((c[5] ^ rx.fb[p][b]) ? dslf_pkg::CRC_POLY : 6'h00);
      end
      return c;
   endfunction

   task automatic t_regs();
      logic [31:0] r;
      logic e;
      apb(dslf_pkg::REG_CTRL, 1'b0, 32'h0, r, e);
      chk("ctrl_reset", r, dslf_pkg::CTRL_RST);
      apb(dslf_pkg::REG_OVH, 1'b0, 32'h0, r, e);
      chk("ovh_reset", r, 32'h0);
      apb(12'h00C, 1'b0, 32'h0, r, e);
      chk("unmapped_err", {31'h0, e}, 32'h1);
      apb(dslf_pkg::REG_OVH, 1'b1, 32'h0230_2008, r, e);
      apb(dslf_pkg::REG_OVH, 1'b0, 32'h0, r, e);
      chk("ovh_back", r, 32'h0230_2008);
      feed_lim = 6;
      repeat (20) @(posedge core_clk);
      apb(dslf_pkg::REG_STAT, 1'b0, 32'h0, r, e);
      chk("fill_level", {27'h0, r[4:0]}, 32'(taken));
      chk("no_symbols_off", 32'(nsym), 32'h0);
      apb(dslf_pkg::REG_CTRL, 1'b1, 32'h0000_0007, r, e);
   endtask

   task automatic t_frame();
      logic [31:0] r;
      logic e;
      int t0;
      wait_sof(1000);
      t0 = cyc;
      feed_lim = 1_000_000;
      apb(dslf_pkg::REG_STAT, 1'b0, 32'h0, r, e);
      chk("stuff_low_fill", {31'h0, r[8]}, 32'h1);
      wait_sof(70000);
      chk("frame_time", 32'(cyc - t0 >= 60000 && cyc - t0 <= 60052), 32'h1);
      apb(dslf_pkg::REG_STAT, 1'b0, 32'h0, r, e);
      chk("stuff_full", {31'h0, r[8]}, 32'h0);
      chk("underrun", {31'h0, r[9]}, 32'h0);
      chk("frames_sent", {16'h0, r[31:16]}, 32'h1);
      chk("rx_frames", 32'(frames), 32'h2);
      chk("frame_len", 32'(frame_len), 32'd2353);
      for (int p = 0; p < dslf_pkg::NP; p++) begin
         chk("sync", 32'(rx.fb[p][1:14]), 32'(SYNC));
         chk("hdr_flags", 32'(rx.fb[p][15:16]), 32'h2);
         chk("first_byte", 32'(rx.fb[p][17:24]), 32'(p));
         chk("stuff_bits", 32'(rx.fb[p][4703:4706]), 32'(dslf_pkg::STUFF_PAT));
         chk("frame_check", 32'(dut.crc_prev[p]), 32'(crc_ref(p)));
      end
      chk("power_status", 32'(rx.fb[0][1187:1188]), 32'h0);
      chk("eoc_first", 32'(rx.fb[0][1181]), 32'h1);
      chk("regen_present", 32'(rx.fb[0][2361]), 32'h1);
      chk("core_sof_seen", 32'(nsof > 0), 32'h1);
   endtask

   // mode is only changed while disabled; symbol pace counted over 1000 cycles
   task automatic t_modes();
      logic [31:0] r;
      logic e;
      int n0;
      int d;
      int exp_n;
      apb(dslf_pkg::REG_CTRL, 1'b1, 32'h0000_0006, r, e);
      repeat (50) @(posedge core_clk);
      n0 = nsym;
      repeat (100) @(posedge core_clk);
      chk("idle_when_off", 32'(nsym - n0), 32'h0);
      for (int m = 1; m <= 2; m++) begin
         apb(dslf_pkg::REG_CTRL, 1'b1, 32'(2 * m + 1), r, e);
         repeat (20) @(posedge core_clk);
         n0 = nsym;
         repeat (1000) @(posedge core_clk);
         d = nsym - n0;
         exp_n = ((m == 1) ? dslf_pkg::BAUD_1 : dslf_pkg::BAUD_2) / (dslf_pkg::CLK_HZ / 1000);
         chk("symbol_pace", 32'(d >= exp_n - 1 && d <= exp_n + 1), 32'h1);
         apb(dslf_pkg::REG_CTRL, 1'b1, 32'(2 * m), r, e);
      end
   endtask

   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      app_valid = 1'b0;
      app_data = 8'h00;
      errors = 0;
      n_tests = 0;
      cyc = 0;
      nsym = 0;
      nsof = 0;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      t_regs();
      t_frame();
      t_modes();
      close_out();
   end
endmodule // dsl_core_and_line_framer_tb
